// *** dtm_top.sv ***
// dtm_top: digital test multiplexer with its two select registers.
// assumes one clock; internal signals and the test pin are synchronous
// to core_clk; clocks routed out are resampled at 25 MHz.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module dtm_top
	import dtm_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// register port
	input wire logic [DTM_ADDR_W-1:0] reg_addr,
	input wire logic [DTM_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DTM_DATA_W-1:0] reg_rdata,
	// flags for the output side
	input wire logic [11:0] supply_monitor_flags,
	input wire logic [3:0] front_end_diag_flags,
	input wire logic wire_wake_low_comparator,
	input wire logic wire_wake_high_comparator,
	// clocks for the output side
	input wire logic main_oscillator,
	input wire logic watchdog_oscillator,
	input wire logic crystal_oscillator,
	input wire logic charge_pump_clock,
	input wire logic pressure_converter_clock,
	input wire logic temperature_converter_clock,
	input wire logic chopper_clock,
	input wire logic capacitive_front_clock,
	// bitstreams and pulses for the output side
	input wire logic pressure_modulator_bits,
	input wire logic pressure_modulator_error,
	input wire logic temperature_modulator_bits,
	input wire logic memory_selftest_retention_stop,
	input wire logic decimator_load_first,
	input wire logic decimator_load_second,
	input wire logic temperature_decimator_load,
	input wire logic [DTM_INT_W-1:0] external_interrupt_source,
	// test pins
	input wire logic digital_test_input,
	output logic first_test_output,
	output logic second_test_output,
	// normal sources of the steerable nodes
	input wire logic otp_clock_src,
	input wire logic pressure_converter_bits_src,
	input wire logic temperature_converter_bits_src,
	input wire logic charge_pump_clock_src,
	input wire logic [DTM_INT_W-1:0] interrupt_acknowledge_src,
	// steerable nodes
	output logic otp_clock,
	output logic pressure_converter_bits_in,
	output logic temperature_converter_bits_in,
	output logic pressure_modulator_clock,
	output logic temperature_modulator_clock,
	output logic chopper_clock_node,
	output logic charge_pump_clock_in,
	output logic [DTM_INT_W-1:0] interrupt_acknowledge_line
);

	////////////////////////////////////////////////////////////////////
	// select registers

	logic [DTM_DATA_W-1:0] test_out_select;
	logic [DTM_DATA_W-1:0] test_in_select;
	logic wr_out_sel;
	logic wr_in_sel;

	// write decode
	assign wr_out_sel = reg_wr && (reg_addr == DTM_OFS_OUT_SEL);
	assign wr_in_sel = reg_wr && (reg_addr == DTM_OFS_IN_SEL);

	// output-select register, whole byte kept
	// field reset to zero
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			test_out_select <= DTM_RESET_VAL;
		end else if (wr_out_sel) begin
			test_out_select <= reg_wdata;
		end
	end

	// input-select register, whole byte kept
	// field reset to zero
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			test_in_select <= DTM_RESET_VAL;
		end else if (wr_in_sel) begin
			test_in_select <= reg_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////
	// output candidates, indexed by output-select code

	logic [DTM_OUT_CODES-1:0] first_cand;
	logic [DTM_OUT_CODES-1:0] second_cand;

	assign first_cand[0] = 1'b0;
	assign second_cand[0] = 1'b0;

	for (genvar g = 0; g < DTM_OUT_SUPPLY_PAIRS; g++) begin : g_supply
		assign first_cand[DTM_OUT_SUPPLY_BASE + g] = supply_monitor_flags[2 * g];
		assign second_cand[DTM_OUT_SUPPLY_BASE + g] = supply_monitor_flags[2 * g + 1];
	end

	for (genvar g = 0; g < DTM_OUT_DIAG_PAIRS; g++) begin : g_diag
		assign first_cand[DTM_OUT_DIAG_BASE + g] = front_end_diag_flags[2 * g];
		assign second_cand[DTM_OUT_DIAG_BASE + g] = front_end_diag_flags[2 * g + 1];
	end

	assign first_cand[DTM_OUT_WAKE] = wire_wake_low_comparator;
	assign second_cand[DTM_OUT_WAKE] = wire_wake_high_comparator;

	assign first_cand[DTM_OUT_OSC] = main_oscillator;
	assign second_cand[DTM_OUT_OSC] = watchdog_oscillator;

	assign first_cand[DTM_OUT_XTAL] = crystal_oscillator;
	assign second_cand[DTM_OUT_XTAL] = charge_pump_clock;

	assign first_cand[DTM_OUT_CONV] = pressure_converter_clock;
	assign second_cand[DTM_OUT_CONV] = temperature_converter_clock;

	assign first_cand[DTM_OUT_CHOP] = chopper_clock;
	assign second_cand[DTM_OUT_CHOP] = capacitive_front_clock;

	assign first_cand[DTM_OUT_PMOD] = pressure_modulator_bits;
	assign second_cand[DTM_OUT_PMOD] = pressure_modulator_error;

	assign first_cand[DTM_OUT_TMOD] = temperature_modulator_bits;
	assign second_cand[DTM_OUT_TMOD] = memory_selftest_retention_stop;

	assign first_cand[DTM_OUT_DECIM] = decimator_load_first;
	assign second_cand[DTM_OUT_DECIM] = decimator_load_second;

	assign first_cand[DTM_OUT_TDECIM] = temperature_decimator_load;
	assign second_cand[DTM_OUT_TDECIM] = external_interrupt_source[DTM_INT_SOLO];

	for (genvar g = 0; g < DTM_OUT_INT_PAIRS; g++) begin : g_int
		assign first_cand[DTM_OUT_INT_BASE + g] =
			external_interrupt_source[DTM_INT_PAIR_BASE + 2 * g];
		assign second_cand[DTM_OUT_INT_BASE + g] =
			external_interrupt_source[DTM_INT_PAIR_BASE + 2 * g + 1];
	end

	////////////////////////////////////////////////////////////////////
	// output selection and pin flops

	logic next_first_out;
	logic next_second_out;
	logic out_code_ok;

	// pair picker on the low five bits
	dtm_out_mux #(
		.NUM_CODES(DTM_OUT_CODES),
		.SEL_W(DTM_OUT_SEL_W)
	) u_out_mux (
		.code(test_out_select[DTM_OUT_SEL_W-1:0]),
		.first_cand(first_cand),
		.second_cand(second_cand),
		.first_pick(next_first_out),
		.second_pick(next_second_out),
		.code_valid(out_code_ok)
	);

	// test pins, one cycle behind the selected source
	// zero when code unlisted
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			first_test_output <= 1'b0;
			second_test_output <= 1'b0;
		end else begin
			first_test_output <= next_first_out;
			second_test_output <= next_second_out;
		end
	end

	////////////////////////////////////////////////////////////////////
	// input steering

	logic [DTM_NODES-1:0] node_normal;
	logic [DTM_NODES-1:0] node_steered;
	logic in_code_ok;

	// normal sources of each node
	assign node_normal[DTM_NODE_OTP] = otp_clock_src;
	assign node_normal[DTM_NODE_PBITS] = pressure_converter_bits_src;
	assign node_normal[DTM_NODE_TBITS] = temperature_converter_bits_src;
	assign node_normal[DTM_NODE_PMOD] = pressure_converter_clock;
	assign node_normal[DTM_NODE_TMOD] = temperature_converter_clock;
	assign node_normal[DTM_NODE_CHOP] = chopper_clock;
	assign node_normal[DTM_NODE_PUMP] = charge_pump_clock_src;
	assign node_normal[DTM_NODE_ACK_BASE] = interrupt_acknowledge_src[DTM_INT_SOLO];
	// acknowledge lines 7 to 10 follow line 5
	for (genvar g = 1; g < DTM_NODES - DTM_NODE_ACK_BASE; g++) begin : g_ack_src
		assign node_normal[DTM_NODE_ACK_BASE + g] =
			interrupt_acknowledge_src[DTM_INT_PAIR_BASE + g - 1];
	end

	// one node at most takes the test pin
	// codes 01 to 0C
	dtm_in_steer #(
		.NUM_NODES(DTM_NODES),
		.SEL_W(DTM_IN_SEL_W)
	) u_in_steer (
		.code(test_in_select[DTM_IN_SEL_W-1:0]),
		.test_in(digital_test_input),
		.normal_in(node_normal),
		.node_out(node_steered),
		.code_valid(in_code_ok)
	);

	// node flops; code 00 leaves every node on its own source
	// ground code steers nothing
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			otp_clock <= 1'b0;
			pressure_converter_bits_in <= 1'b0;
			temperature_converter_bits_in <= 1'b0;
			pressure_modulator_clock <= 1'b0;
			temperature_modulator_clock <= 1'b0;
			chopper_clock_node <= 1'b0;
			charge_pump_clock_in <= 1'b0;
		end else begin
			otp_clock <= node_steered[DTM_NODE_OTP];
			pressure_converter_bits_in <= node_steered[DTM_NODE_PBITS];
			temperature_converter_bits_in <= node_steered[DTM_NODE_TBITS];
			pressure_modulator_clock <= node_steered[DTM_NODE_PMOD];
			temperature_modulator_clock <= node_steered[DTM_NODE_TMOD];
			chopper_clock_node <= node_steered[DTM_NODE_CHOP];
			charge_pump_clock_in <= node_steered[DTM_NODE_PUMP];
		end
	end

	logic [DTM_INT_W-1:0] next_ack;

	// acknowledge lines: 5 and 7 to 10 steerable, the rest pass
	// acknowledge lines 5, 7 to 10
	always_comb begin
		next_ack = interrupt_acknowledge_src;
		next_ack[DTM_INT_SOLO] = node_steered[DTM_NODE_ACK_BASE];
		for (int i = 1; i < DTM_NODES - DTM_NODE_ACK_BASE; i++) begin
			next_ack[DTM_INT_PAIR_BASE + i - 1] = node_steered[DTM_NODE_ACK_BASE + i];
		end
	end

	// acknowledge flops
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			interrupt_acknowledge_line <= '0;
		end else begin
			interrupt_acknowledge_line <= next_ack;
		end
	end

	////////////////////////////////////////////////////////////////////
	// status and read-back

	logic [DTM_DATA_W-1:0] status_word;
	logic input_seen;
	logic [DTM_DATA_W-1:0] next_rdata;

	// test pin level as seen by the block; grounded under code 00
	// ground reference
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			input_seen <= 1'b0;
		end else begin
			input_seen <= (test_in_select[DTM_IN_SEL_W-1:0] != '0) && digital_test_input;
		end
	end

	// live view of pins and code validity
	always_comb begin
		status_word = '0;
		status_word[DTM_ST_FIRST] = first_test_output;
		status_word[DTM_ST_SECOND] = second_test_output;
		status_word[DTM_ST_INPUT] = input_seen;
		status_word[DTM_ST_OUT_OK] = out_code_ok;
		status_word[DTM_ST_IN_OK] = in_code_ok;
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		next_rdata = '0;
		if (reg_rd) begin
			case (reg_addr)
				DTM_OFS_OUT_SEL: begin
					next_rdata = test_out_select;
				end
				DTM_OFS_IN_SEL: begin
					next_rdata = test_in_select;
				end
				DTM_OFS_STATUS: begin
					next_rdata = status_word;
				end
				default: begin
					next_rdata = '0;
				end
			endcase
		end
	end

	// read data stands one cycle after the strobe, zero otherwise
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

endmodule // dtm_top
`default_nettype wire

// *** dtm_pkg.sv ***
// dtm_pkg: constants for the digital test multiplexer.
// assumes a byte-wide register port with printed offsets as addresses.
// Operation
// - The output-select field is bits 4:0 of the test-out register, reset to zero, where code 00 gives zero on both test outputs, 01 to 06 give supply-monitor flag pairs and 07 to 08 give diagnostic flag pairs.
// - Code 09 puts the low and high wake comparator outputs on the first and second test outputs.
// - Code 0A puts the main oscillator on the first test output and the watchdog oscillator on the second.
// - Code 0B puts the crystal oscillator on the first test output and the charge-pump clock on the second.
// - Code 0C puts the pressure converter clock on the first test output and the temperature converter clock on the second.
// - Code 0D puts the chopper clock on the first test output and the capacitive front-end clock on the second.
// - Code 0E puts the pressure modulator bitstream and its error output on the two test outputs.
// - Code 0F puts the temperature modulator bitstream and the memory self-test retention stop on the two test outputs.
// - Code 10 puts the first and second decimator load pulses on the two test outputs.
// - Code 11 gives the temperature decimator load and interrupt source 5, and codes 12 to 14 give interrupt source pairs 7/8, 9/10 and 11/12.
// - The input-select field is bits 3:0 of the test-in register, reset to zero, and code 00 ties the test input to ground only.
// - Input codes 01 to 03 feed the test input to the programmable-memory clock and the pressure and temperature converter bitstream nodes.
// - Input codes 04 to 07 feed the modulator, chopper and charge-pump clocks, and 08 to 0C feed acknowledge lines 5, 7, 8, 9 and 10.
package dtm_pkg;
	// register port
	localparam int DTM_ADDR_W = 8;
	localparam int DTM_DATA_W = 8;
	localparam logic [7:0] DTM_OFS_OUT_SEL = 8'h07;
	localparam logic [7:0] DTM_OFS_IN_SEL = 8'h09;
	localparam logic [7:0] DTM_OFS_STATUS = 8'h0A;
	localparam logic [7:0] DTM_RESET_VAL = 8'h00;
	// select fields
	localparam int DTM_OUT_SEL_W = 5;
	localparam int DTM_IN_SEL_W = 4;
	// output-select codes
	localparam int DTM_OUT_SUPPLY_BASE = 1;
	localparam int DTM_OUT_SUPPLY_PAIRS = 6;
	localparam int DTM_OUT_DIAG_BASE = 7;
	localparam int DTM_OUT_DIAG_PAIRS = 2;
	localparam int DTM_OUT_WAKE = 9;
	localparam int DTM_OUT_OSC = 10;
	localparam int DTM_OUT_XTAL = 11;
	localparam int DTM_OUT_CONV = 12;
	localparam int DTM_OUT_CHOP = 13;
	localparam int DTM_OUT_PMOD = 14;
	localparam int DTM_OUT_TMOD = 15;
	localparam int DTM_OUT_DECIM = 16;
	localparam int DTM_OUT_TDECIM = 17;
	localparam int DTM_OUT_INT_BASE = 18;
	localparam int DTM_OUT_INT_PAIRS = 3;
	localparam int DTM_OUT_CODES = 21;
	// interrupt source and acknowledge indices
	localparam int DTM_INT_W = 13;
	localparam int DTM_INT_SOLO = 5;
	localparam int DTM_INT_PAIR_BASE = 7;
	// internal nodes fed by input codes 1 upward
	localparam int DTM_NODE_OTP = 0;
	localparam int DTM_NODE_PBITS = 1;
	localparam int DTM_NODE_TBITS = 2;
	localparam int DTM_NODE_PMOD = 3;
	localparam int DTM_NODE_TMOD = 4;
	localparam int DTM_NODE_CHOP = 5;
	localparam int DTM_NODE_PUMP = 6;
	localparam int DTM_NODE_ACK_BASE = 7;
	localparam int DTM_NODES = 12;
	// status register bits
	localparam int DTM_ST_FIRST = 0;
	localparam int DTM_ST_SECOND = 1;
	localparam int DTM_ST_INPUT = 2;
	localparam int DTM_ST_OUT_OK = 3;
	localparam int DTM_ST_IN_OK = 4;
endpackage

// *** dtm_out_mux.sv ***
// dtm_out_mux: picks one candidate pair by output-select code.
// assumes candidate index equals the code; index 0 is tied low.
`timescale 1ns/1ns
`default_nettype none
module dtm_out_mux
	import dtm_pkg::*;
#(
	parameter int NUM_CODES = DTM_OUT_CODES,
	parameter int SEL_W = DTM_OUT_SEL_W
) (
	// select
	input wire logic [SEL_W-1:0] code,
	// candidates
	input wire logic [NUM_CODES-1:0] first_cand,
	input wire logic [NUM_CODES-1:0] second_cand,
	// picked pair
	output logic first_pick,
	output logic second_pick,
	output logic code_valid
);
	// selection with out-of-range codes giving zero
	always_comb begin
		code_valid = (int'(code) < NUM_CODES);
		first_pick = 1'b0;
		second_pick = 1'b0;
		if (code_valid) begin
			first_pick = first_cand[code];
			second_pick = second_cand[code];
		end
	end
endmodule // dtm_out_mux
`default_nettype wire

// *** dtm_in_steer.sv ***
// dtm_in_steer: steers the test input onto one internal node.
// assumes node g is taken by input-select code g+1; code 0 takes none.
`timescale 1ns/1ns
`default_nettype none
module dtm_in_steer
	import dtm_pkg::*;
#(
	parameter int NUM_NODES = DTM_NODES,
	parameter int SEL_W = DTM_IN_SEL_W
) (
	// select and pin
	input wire logic [SEL_W-1:0] code,
	input wire logic test_in,
	// node sources and results
	input wire logic [NUM_NODES-1:0] normal_in,
	output logic [NUM_NODES-1:0] node_out,
	output logic code_valid
);
	// one steering cell per node
	for (genvar g = 0; g < NUM_NODES; g++) begin : g_node
		assign node_out[g] = (int'(code) == g + 1) ? test_in : normal_in[g];
	end
	// codes above the last node leave all nodes alone
	assign code_valid = (int'(code) <= NUM_NODES);
endmodule // dtm_in_steer
`default_nettype wire

// *** dtm_vpkg.sv ***
// dtm_vpkg: expectation helpers shared by the checker and the bench.
// assumes the flat source order: supply flags at bit 0 up to interrupt sources at 33.
`default_nettype none
package dtm_vpkg;
	// pair on the test pins for an out code; bit 0 is the first pin
	function automatic logic [1:0] exp_pair(input logic [4:0] c, input logic [45:0] f);
		if (c >= 5'h01 && c <= 5'h10) return {f[2*c-1], f[2*c-2]};
		if (c == 5'h11) return {f[38], f[32]};
		if (c >= 5'h12 && c <= 5'h14) return {f[2*c+5], f[2*c+4]};
		return 2'b00;
	endfunction

	// steerable node values for an in code
	function automatic logic [19:0] exp_nodes(input logic [3:0] c, input logic tin,
		input logic [45:0] f, input logic [16:0] n);
		logic [19:0] v;
		int g;
		v = {n[16:4], n[3], f[24], f[23], f[22], n[2:0]};
		g = int'(c) - 1;
		if (c >= 4'h1 && c <= 4'hc) v[g < 7 ? g : (g == 7 ? 12 : g + 6)] = tin;
		return v;
	endfunction
endpackage
`default_nettype wire

// *** dtm_fixture.sv ***
// dtm_fixture: test equipment on the test pins.
// assumes pins are sampled on core_clk; drives a new test input bit each cycle.
`timescale 1ns/1ns
`default_nettype none
module dtm_fixture (
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// test pins
	input wire logic first_test_output,
	input wire logic second_test_output,
	output logic digital_test_input
);
	logic [7:0] lfsr;
	logic [1:0] probe;
	assign digital_test_input = lfsr[0];
	// test input pattern and debug probing
	// pattern generator and pin probe
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			lfsr <= 8'h01;
			probe <= 2'b00;
		end else begin
			lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
			probe <= {second_test_output, first_test_output};
		end
	end
endmodule // dtm_fixture
`default_nettype wire

// *** dtm_top_checker.sv ***
// dtm_top_checker: pin and register relations of the test multiplexer.
// assumes one clock domain; bound into dtm_top.
`timescale 1ns/1ns
`default_nettype none
module dtm_top_checker
	import dtm_pkg::*;
	import dtm_vpkg::*;
(
	// clock, reset, register port
	input wire logic core_clk, rstn, reg_wr, reg_rd,
	input wire logic [DTM_ADDR_W-1:0] reg_addr,
	input wire logic [DTM_DATA_W-1:0] reg_wdata, reg_rdata,
	// sources
	input wire logic [11:0] supply_monitor_flags,
	input wire logic [3:0] front_end_diag_flags,
	input wire logic [DTM_INT_W-1:0] external_interrupt_source, interrupt_acknowledge_src,
	input wire logic wire_wake_low_comparator, wire_wake_high_comparator, main_oscillator,
	input wire logic watchdog_oscillator, crystal_oscillator, charge_pump_clock, chopper_clock,
	input wire logic pressure_converter_clock, temperature_converter_clock, capacitive_front_clock,
	input wire logic pressure_modulator_bits, pressure_modulator_error, temperature_modulator_bits,
	input wire logic memory_selftest_retention_stop, decimator_load_first, decimator_load_second,
	input wire logic temperature_decimator_load, digital_test_input, otp_clock_src,
	input wire logic pressure_converter_bits_src, temperature_converter_bits_src,
	input wire logic charge_pump_clock_src,
	// pins and nodes
	input wire logic first_test_output, second_test_output, otp_clock,
	input wire logic pressure_converter_bits_in, temperature_converter_bits_in, chopper_clock_node,
	input wire logic pressure_modulator_clock, temperature_modulator_clock, charge_pump_clock_in,
	input wire logic [DTM_INT_W-1:0] interrupt_acknowledge_line
);
	logic [7:0] sh_o, sh_i;
	logic [45:0] f;
	logic [16:0] n;
	logic [19:0] nodes, nx, nn;
	logic e1, e2, live;
	logic [7:0] ack_src_fix, ack_fix;
	// flat source and node views
	assign f = {external_interrupt_source, temperature_decimator_load, decimator_load_second,
		decimator_load_first, memory_selftest_retention_stop, temperature_modulator_bits,
		pressure_modulator_error, pressure_modulator_bits, capacitive_front_clock, chopper_clock,
		temperature_converter_clock, pressure_converter_clock, charge_pump_clock, crystal_oscillator,
		watchdog_oscillator, main_oscillator, wire_wake_high_comparator, wire_wake_low_comparator,
		front_end_diag_flags, supply_monitor_flags};
	assign n = {interrupt_acknowledge_src, charge_pump_clock_src, temperature_converter_bits_src,
		pressure_converter_bits_src, otp_clock_src};
	assign nodes = {interrupt_acknowledge_line, charge_pump_clock_in, chopper_clock_node,
		temperature_modulator_clock, pressure_modulator_clock, temperature_converter_bits_in,
		pressure_converter_bits_in, otp_clock};
	assign {e2, e1} = exp_pair(sh_o[4:0], f);
	assign nx = exp_nodes(sh_i[3:0], digital_test_input, f, n);
	assign nn = exp_nodes(4'h0, 1'b0, f, n);
	assign ack_src_fix = {interrupt_acknowledge_src[12:11], interrupt_acknowledge_src[6],
		interrupt_acknowledge_src[4:0]};
	assign ack_fix = {interrupt_acknowledge_line[12:11], interrupt_acknowledge_line[6],
		interrupt_acknowledge_line[4:0]};
	// shadow of the two select registers
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			sh_o <= 8'h00;
			sh_i <= 8'h00;
		end else if (reg_wr) begin
			if (reg_addr == DTM_OFS_OUT_SEL) sh_o <= reg_wdata;
			if (reg_addr == DTM_OFS_IN_SEL) sh_i <= reg_wdata;
		end
	end
	// low while flops still show their reset values
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			live <= 1'b0;
		end else begin
			live <= 1'b1;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	property p_rd_out; reg_rd && reg_addr == DTM_OFS_OUT_SEL |=> reg_rdata == $past(sh_o); endproperty
	a_rd_out: assert property (p_rd_out) else $error("out select read back wrong");
	property p_rd_in; reg_rd && reg_addr == DTM_OFS_IN_SEL |=> reg_rdata == $past(sh_i); endproperty
	a_rd_in: assert property (p_rd_in) else $error("in select read back wrong");
	property p_pins_zero;
		(sh_o[4:0] == 5'h00 || sh_o[4:0] > 5'h14) |=> !first_test_output && !second_test_output;
	endproperty
	a_pins_zero: assert property (p_pins_zero) else $error("test pins not zero");
	property p_first; 1'b1 |=> first_test_output == $past(e1); endproperty
	a_first: assert property (p_first) else $error("first pin wrong");
	property p_second; 1'b1 |=> second_test_output == $past(e2); endproperty
	a_second: assert property (p_second) else $error("second pin wrong");
	property p_nodes; live |=> nodes == $past(nx); endproperty
	a_nodes: assert property (p_nodes) else $error("steered nodes wrong");
	property p_nodes_idle; live && (sh_i[3:0] == 4'h0 || sh_i[3:0] > 4'hc) |=> nodes == $past(nn); endproperty
	a_nodes_idle: assert property (p_nodes_idle) else $error("node left steered");
	property p_ack_fixed; live |=> ack_fix == $past(ack_src_fix); endproperty
	a_ack_fixed: assert property (p_ack_fixed) else $error("fixed acknowledge moved");
	property p_status;
		live && reg_rd && reg_addr == DTM_OFS_STATUS |=> reg_rdata == {3'b000,
			$past(sh_i[3:0] <= 4'hc), $past(sh_o[4:0] <= 5'h14),
			$past(sh_i[3:0] != 4'h0 && digital_test_input, 2),
			$past(second_test_output), $past(first_test_output)};
	endproperty
	a_status: assert property (p_status) else $error("status word wrong");
	c_wake: cover property (sh_o[4:0] == 5'h09 && first_test_output);
	c_steer: cover property (sh_i[3:0] == 4'hc);
	c_rd: cover property (reg_rd && reg_addr == DTM_OFS_IN_SEL);
endmodule // dtm_top_checker
bind dtm_top dtm_top_checker u_chk (.*);
`default_nettype wire

// *** digital_test_mux_tb.sv ***
// digital_test_mux_tb: random sources, every select code, register reads.
// assumes the design answers reads one cycle later and pins lag one cycle.
`timescale 1ns/1ns
`default_nettype none
module digital_test_mux_tb;
	import dtm_pkg::*;
	import dtm_vpkg::*;
	logic core_clk, rstn, reg_wr, reg_rd;
	logic [DTM_ADDR_W-1:0] reg_addr;
	logic [DTM_DATA_W-1:0] reg_wdata, reg_rdata, mo, mi;
	logic [11:0] supply_monitor_flags;
	logic [3:0] front_end_diag_flags;
	logic [DTM_INT_W-1:0] external_interrupt_source, interrupt_acknowledge_src;
	logic [DTM_INT_W-1:0] interrupt_acknowledge_line;
	logic wire_wake_low_comparator, wire_wake_high_comparator, main_oscillator;
	logic watchdog_oscillator, crystal_oscillator, charge_pump_clock, chopper_clock;
	logic pressure_converter_clock, temperature_converter_clock, capacitive_front_clock;
	logic pressure_modulator_bits, pressure_modulator_error, temperature_modulator_bits;
	logic memory_selftest_retention_stop, decimator_load_first, decimator_load_second;
	logic temperature_decimator_load, digital_test_input, otp_clock_src;
	logic pressure_converter_bits_src, temperature_converter_bits_src, charge_pump_clock_src;
	logic first_test_output, second_test_output, otp_clock, chopper_clock_node;
	logic pressure_converter_bits_in, temperature_converter_bits_in, charge_pump_clock_in;
	logic pressure_modulator_clock, temperature_modulator_clock;
	logic [45:0] fsrc = '0;
	logic [16:0] nsrc = '0;
	logic [19:0] nodes, en;
	logic [1:0] ep;
	int mismatches = 0;
	int n_checks = 0;
	int cyc = 0;
	// random sources onto the named inputs
	assign {external_interrupt_source, temperature_decimator_load, decimator_load_second,
		decimator_load_first, memory_selftest_retention_stop, temperature_modulator_bits,
		pressure_modulator_error, pressure_modulator_bits, capacitive_front_clock, chopper_clock,
		temperature_converter_clock, pressure_converter_clock, charge_pump_clock, crystal_oscillator,
		watchdog_oscillator, main_oscillator, wire_wake_high_comparator, wire_wake_low_comparator,
		front_end_diag_flags, supply_monitor_flags} = fsrc;
	assign {interrupt_acknowledge_src, charge_pump_clock_src, temperature_converter_bits_src,
		pressure_converter_bits_src, otp_clock_src} = nsrc;
	assign nodes = {interrupt_acknowledge_line, charge_pump_clock_in, chopper_clock_node,
		temperature_modulator_clock, pressure_modulator_clock, temperature_converter_bits_in,
		pressure_converter_bits_in, otp_clock};
	dtm_top DUT (.*);
	dtm_fixture u_fix (.core_clk(core_clk), .rstn(rstn), .first_test_output(first_test_output),
		.second_test_output(second_test_output), .digital_test_input(digital_test_input));
	always #20 core_clk = ~core_clk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_sim();
		if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		check(32'(reg_rdata), 32'(e), "rdata");
	endtask
	task automatic sel(input logic [7:0] a, input logic [7:0] d);
		wr(a, d);
		repeat (6) @(posedge core_clk);
		rd(a, d);
	endtask
	// pin and node monitor, model of the selects, fresh random sources
	always @(posedge core_clk) begin
		cyc++;
		if (cyc > 5000) begin
			mismatches++;
			end_sim();
		end
		if (!rstn) begin
			mo = 8'h00;
			mi = 8'h00;
			ep = 2'b00;
			en = '0;
		end else begin
			check(32'({second_test_output, first_test_output}), 32'(ep), "pins");
			check(32'(nodes), 32'(en), "nodes");
			ep = exp_pair(mo[4:0], fsrc);
			en = exp_nodes(mi[3:0], digital_test_input, fsrc, nsrc);
			if (reg_wr && reg_addr == DTM_OFS_OUT_SEL) mo = reg_wdata;
			if (reg_wr && reg_addr == DTM_OFS_IN_SEL) mi = reg_wdata;
		end
		fsrc <= 46'({$urandom(), $urandom()});
		nsrc <= 17'($urandom());
	end
	// main sequence
	initial begin
		core_clk = 1'b0;
		rstn = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		void'($urandom(32'h5d86));
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		rd(DTM_OFS_OUT_SEL, DTM_RESET_VAL);
		rd(DTM_OFS_IN_SEL, DTM_RESET_VAL);
		rd(DTM_OFS_STATUS, 8'h18);
		// status ignores writes
		wr(DTM_OFS_STATUS, 8'hff);
		rd(DTM_OFS_STATUS, 8'h18);
		// unmapped place keeps nothing
		wr(8'h08, 8'hff);
		rd(8'h08, 8'h00);
		// every code of both selects, random upper bits
		for (int c = 0; c < 32; c++) sel(DTM_OFS_OUT_SEL, {3'($urandom()), 5'(c)});
		for (int c = 0; c < 16; c++) sel(DTM_OFS_IN_SEL, {4'($urandom()), 4'(c)});
		// writes on both selects, one idle cycle apart
		wr(DTM_OFS_OUT_SEL, 8'h14);
		wr(DTM_OFS_IN_SEL, 8'h0c);
		for (int i = 0; i < 30; i++) sel($urandom_range(1) ? DTM_OFS_OUT_SEL : DTM_OFS_IN_SEL,
			8'($urandom()));
		// reset in mid run clears both selects
		@(posedge core_clk);
		rstn <= 1'b0;
		@(posedge core_clk);
		rstn <= 1'b1;
		rd(DTM_OFS_OUT_SEL, DTM_RESET_VAL);
		rd(DTM_OFS_IN_SEL, DTM_RESET_VAL);
		end_sim();
	end
endmodule // digital_test_mux_tb
`default_nettype wire
